/* acs_id_mem.sv */
// Small ID store for locally answered stash-once requests
`timescale 1ns/100ps
module acs_id_mem #(
  parameter int W = 4,
  parameter int DEPTH = 8,
  parameter int PTR_W = $clog2(DEPTH)
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [PTR_W-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [PTR_W-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);

  logic [W-1:0] mem_q [DEPTH];

  // Write-first read, so a freshly pushed ID is visible one cycle later
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule

/* acs_bridge.sv */
// Stash request bridge: package with constants, then the bridge top module
//
// Contract
// RULE1 - No stash support means stash signals absent
// RULE2 - Stash-capable snoop field is four bits wide
// RULE3 - Master encodes stash opcodes 8, 9, C, D
// RULE4 - Master sets lock, barrier, cache, domain legally
// RULE5 - Master keeps stash inside one cache line
// RULE6 - Node id 11 bits, processor id 5 bits
// RULE7 - Each identifier travels with its enable
// RULE8 - Node id zero while its enable low
// RULE9 - Processor id zero while its enable low
// RULE10 - Non-stash requests hold both enables low
// RULE11 - Either enable alone or both allowed
// RULE12 - Target never changes who may cache line
// RULE13 - Targetless write stash: holder or system cache
// RULE14 - Targetless stash-once: system cache if uncached
// RULE15 - Stash-once: one address, one response, no data
// RULE16 - Write stash keeps unique write structure
// RULE17 - Master never mixes stash-once ID kinds
// RULE18 - Many outstanding requests may share one ID
// RULE19 - Partial write stash becomes plain unique write
// RULE20 - Full write stash becomes full-line unique write
// RULE21 - Stash-once not forwarded, answered locally
// RULE22 - Shared keeps copies, unique may invalidate
// RULE23 - Full stash writes all bytes, partial any
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
package acs_pkg;
  // ************************************************************
  // Opcodes and field layout
  // ************************************************************
  localparam logic [3:0] SN_PTL_STASH = 4'h8;
  localparam logic [3:0] SN_FULL_STASH = 4'h9;
  localparam logic [3:0] SN_ONCE_SHARED = 4'hC;
  localparam logic [3:0] SN_ONCE_UNIQUE = 4'hD;
  localparam logic [3:0] SN_UNIQUE = 4'h0;
  localparam logic [3:0] SN_LINE_UNIQUE = 4'h1;
  localparam int SNOOP_W = 4;
  localparam int NID_W = 11;
  localparam int LPID_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  // ************************************************************
  // Register map and reset values
  // ************************************************************
  localparam int WB_ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONV_CNT = 8'h08;
  localparam logic [7:0] REG_ONCE_CNT = 8'h0C;
  localparam int CTRL_FWD_BIT = 0;
  localparam logic CTRL_FWD_RST = 1'b0;
endpackage

`timescale 1ns/100ps
module acs_bridge #(
  parameter int ID_W = 4,
  parameter int ADDR_W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Upstream write address channel with stash extension
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [ID_W-1:0] s_awid_i,
  input wire logic [ADDR_W-1:0] s_awaddr_i,
  input wire logic [7:0] s_awlen_i,
  input wire logic [2:0] s_awsize_i,
  input wire logic [1:0] s_awburst_i,
  input wire logic [acs_pkg::SNOOP_W-1:0] s_awsnoop_i,
  input wire logic [1:0] s_awdomain_i,
  input wire logic [3:0] s_awcache_i,
  input wire logic s_awlock_i,
  input wire logic [1:0] s_awbar_i,
  input wire logic [acs_pkg::NID_W-1:0] s_awstashnid_i,
  input wire logic s_awstashniden_i,
  input wire logic [acs_pkg::LPID_W-1:0] s_awstashlpid_i,
  input wire logic s_awstashlpiden_i,
  // Upstream write response
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  output logic [ID_W-1:0] s_bid_o,
  output logic [1:0] s_bresp_o,
  // Downstream write address channel
  output logic m_awvalid_o,
  input wire logic m_awready_i,
  output logic [ID_W-1:0] m_awid_o,
  output logic [ADDR_W-1:0] m_awaddr_o,
  output logic [7:0] m_awlen_o,
  output logic [2:0] m_awsize_o,
  output logic [1:0] m_awburst_o,
  output logic [acs_pkg::SNOOP_W-1:0] m_awsnoop_o,
  output logic [1:0] m_awdomain_o,
  output logic [3:0] m_awcache_o,
  output logic m_awlock_o,
  output logic [1:0] m_awbar_o,
  output logic [acs_pkg::NID_W-1:0] m_awstashnid_o,
  output logic m_awstashniden_o,
  output logic [acs_pkg::LPID_W-1:0] m_awstashlpid_o,
  output logic m_awstashlpiden_o,
  // Downstream write response
  input wire logic m_bvalid_i,
  output logic m_bready_o,
  input wire logic [ID_W-1:0] m_bid_i,
  input wire logic [1:0] m_bresp_i,
  // Wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [acs_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import acs_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;

  typedef struct packed {
    logic awready;
    logic slot_v;
    logic [ID_W-1:0] id;
    logic [ADDR_W-1:0] addr;
    logic [7:0] len;
    logic [2:0] size;
    logic [1:0] burst;
    logic [SNOOP_W-1:0] snoop;
    logic [1:0] domain;
    logic [3:0] cache;
    logic lock;
    logic [1:0] bar;
    logic [NID_W-1:0] nid;
    logic niden;
    logic [LPID_W-1:0] lpid;
    logic lpiden;
    logic bvalid;
    logic [ID_W-1:0] bid;
    logic [1:0] bresp;
    logic bready;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [CNT_W-1:0] cnt;
    logic fwd;
    logic [31:0] conv_cnt;
    logic [31:0] once_cnt;
    logic ack;
    logic [31:0] dat;
  } acs_state_t;

  acs_state_t q, d;
  logic aw_acc;
  logic is_once;
  logic m_take;
  logic loc_take;
  logic push;
  logic [ID_W-1:0] mem_rdata;

  // ************************************************************
  // Local response ID store
  // ************************************************************
  acs_id_mem #(
    .W(ID_W),
    .DEPTH(DEPTH),
    .PTR_W(PTR_W)
  ) u_id_mem (
    .clk_i(clk_i),
    .we_i(push),
    .waddr_i(q.wptr),
    .wdata_i(s_awid_i),
    .raddr_i(d.rptr),
    .rdata_o(mem_rdata)
  );

  // Request classification and handshakes
  assign aw_acc = s_awvalid_i && q.awready;
  assign is_once = (s_awsnoop_i == SN_ONCE_SHARED) || (s_awsnoop_i == SN_ONCE_UNIQUE);
  assign push = aw_acc && is_once && !q.fwd; // RULE21
  assign m_take = m_bvalid_i && q.bready;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    d = q;
    loc_take = 1'b0;
    // Slot drains once downstream takes the address
    if (q.slot_v && m_awready_i) begin
      d.slot_v = 1'b0;
    end
    // Accepted request: forward, convert or absorb
    if (aw_acc) begin
      if (push) begin
        // Never propagated, so no cached copy is disturbed
        d.wptr = PTR_W'(q.wptr + 1'b1); // RULE21 RULE22
        d.once_cnt = q.once_cnt + 32'h00000001;
      end else begin
        d.slot_v = 1'b1;
        d.id = s_awid_i;
        d.addr = s_awaddr_i;
        d.len = s_awlen_i;
        d.size = s_awsize_i;
        d.burst = s_awburst_i;
        d.domain = s_awdomain_i;
        d.cache = s_awcache_i;
        d.lock = s_awlock_i;
        d.bar = s_awbar_i;
        // Forwarded as-is: a capable downstream home picks a targetless destination
        d.snoop = s_awsnoop_i; // RULE13 RULE14 RULE22
        d.nid = s_awstashnid_i; // RULE6 RULE7 RULE12
        d.niden = s_awstashniden_i; // RULE11
        d.lpid = s_awstashlpid_i;
        d.lpiden = s_awstashlpiden_i;
        if (!q.fwd) begin
          // Downstream lacks stash: strip target, narrow opcode
          d.nid = '0; // RULE1
          d.niden = 1'b0;
          d.lpid = '0;
          d.lpiden = 1'b0;
          if (s_awsnoop_i == SN_PTL_STASH) begin
            d.snoop = SN_UNIQUE; // RULE19
            d.conv_cnt = q.conv_cnt + 32'h00000001;
          end else if (s_awsnoop_i == SN_FULL_STASH) begin
            d.snoop = SN_LINE_UNIQUE; // RULE20
            d.conv_cnt = q.conv_cnt + 32'h00000001;
          end
        end
      end
    end
    // Response stage: downstream first, then local answers
    if (q.bvalid && s_bready_i) begin
      d.bvalid = 1'b0;
    end
    if (m_take) begin
      d.bvalid = 1'b1; // RULE16
      d.bid = m_bid_i;
      d.bresp = m_bresp_i;
    end else if ((!q.bvalid || s_bready_i) && (q.cnt != '0)) begin
      // Only IDs whose address was already taken are answered
      loc_take = 1'b1; // RULE15
      d.bvalid = 1'b1;
      d.bid = mem_rdata;
      d.bresp = RESP_OKAY;
      d.rptr = PTR_W'(q.rptr + 1'b1);
    end
    case ({push, loc_take})
      2'b10: d.cnt = CNT_W'(q.cnt + 1'b1);
      2'b01: d.cnt = CNT_W'(q.cnt - 1'b1);
      default: d.cnt = q.cnt;
    endcase
    d.bready = !d.bvalid;
    // One request per two cycles; refuse while slot or store is full
    d.awready = !aw_acc && !d.slot_v && (d.cnt < CNT_W'(DEPTH)); // RULE18
    // Wishbone: answer one cycle after the strobe, drop ack after one cycle
    d.ack = wb_cyc_i && wb_stb_i && !q.ack;
    d.dat = 32'h00000000;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      case (wb_adr_i)
        REG_CTRL: d.dat[CTRL_FWD_BIT] = q.fwd;
        REG_STATUS: d.dat = {{(32 - CNT_W - 1){1'b0}}, q.slot_v, q.cnt};
        REG_CONV_CNT: d.dat = q.conv_cnt;
        REG_ONCE_CNT: d.dat = q.once_cnt;
        default: d.dat = 32'h00000000;
      endcase
    end
    // Write lands on the edge that samples ack, as a classic master expects
    if (wb_cyc_i && wb_stb_i && q.ack && wb_we_i && wb_sel_i[0] && (wb_adr_i == REG_CTRL)) begin
      d.fwd = wb_dat_i[CTRL_FWD_BIT];
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.fwd <= CTRL_FWD_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign s_awready_o = q.awready;
  assign s_bvalid_o = q.bvalid;
  assign s_bid_o = q.bid;
  assign s_bresp_o = q.bresp;
  assign m_awvalid_o = q.slot_v;
  assign m_awid_o = q.id;
  assign m_awaddr_o = q.addr;
  assign m_awlen_o = q.len;
  assign m_awsize_o = q.size;
  assign m_awburst_o = q.burst;
  assign m_awsnoop_o = q.snoop; // RULE2
  assign m_awdomain_o = q.domain;
  assign m_awcache_o = q.cache;
  assign m_awlock_o = q.lock;
  assign m_awbar_o = q.bar;
  assign m_awstashnid_o = q.nid;
  assign m_awstashniden_o = q.niden;
  assign m_awstashlpid_o = q.lpid;
  assign m_awstashlpiden_o = q.lpiden;
  assign m_bready_o = q.bready;
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ptl_convert: assert property (aw_acc && !q.fwd && s_awsnoop_i == SN_PTL_STASH |=> // RULE19
    m_awvalid_o && m_awsnoop_o == SN_UNIQUE) else $error("partial stash not converted");
  a_full_convert: assert property (aw_acc && !q.fwd && s_awsnoop_i == SN_FULL_STASH |=> // RULE20
    m_awvalid_o && m_awsnoop_o == SN_LINE_UNIQUE) else $error("full stash not converted");
  a_once_absorb: assert property (aw_acc && push |=> !m_awvalid_o ##0 q.cnt != '0) // RULE21
    else $error("stash-once leaked downstream");
  a_once_answer: assert property (push && s_bready_i && !m_bvalid_i |=> ##[0:1] s_bvalid_o) // RULE15
    else $error("stash-once not answered promptly");
  a_no_stash_out: assert property (m_awvalid_o && !q.fwd |-> // RULE1
    !m_awstashniden_o && !m_awstashlpiden_o && m_awsnoop_o[3] == 1'b0) else $error("stash field sent downstream");
  a_nid_zero: assert property (m_awvalid_o && !m_awstashniden_o |-> m_awstashnid_o == '0) // RULE8
    else $error("node id not zero");
  a_fwd_pass: assert property (aw_acc && q.fwd |=> m_awsnoop_o == $past(s_awsnoop_i) // RULE13
    && m_awstashlpid_o == $past(s_awstashlpid_i)) else $error("forwarded stash altered");
  a_aw_hold: assert property (m_awvalid_o && !m_awready_i |=> m_awvalid_o && $stable(m_awaddr_o)) // RULE16
    else $error("downstream address dropped");
  a_b_pass: assert property (m_bvalid_i && m_bready_o |=> s_bvalid_o && s_bid_o == $past(m_bid_i)) // RULE16
    else $error("downstream response lost");
  a_b_hold: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bid_o)) // RULE18
    else $error("response changed while stalled");
  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");

  c_ptl: cover property (aw_acc && !q.fwd && s_awsnoop_i == SN_PTL_STASH);
  c_once_resp: cover property (push ##[1:4] s_bvalid_o && s_bready_i);
  c_fwd_once: cover property (aw_acc && q.fwd && is_once);

endmodule

/* acs_sub_model.sv */
// Downstream write-channel subordinate model for the stash bridge bench
`timescale 1ns/100ps
module acs_sub_model #(
  parameter int ID_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [ID_W-1:0] awid_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [ID_W-1:0] bid_o,
  output logic [1:0] bresp_o
);
  logic busy_q;
  logic [3:0] wait_q;
  // One write in flight, so the bridge must hold its slot while waiting
  assign awready_o = !busy_q && !rst_i;
  // Slow mode stretches the response; idle response lines show inverted junk
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      bvalid_o <= 1'b0;
      bid_o <= '0;
      bresp_o <= 2'h3;
    end else if (awvalid_i && awready_o) begin
      busy_q <= 1'b1;
      bid_o <= awid_i;
      wait_q <= slow_i ? 4'h9 : 4'h1;
    end else if (busy_q && !bvalid_o) begin
      wait_q <= wait_q - 4'h1;
      bvalid_o <= (wait_q == 4'h0);
      bresp_o <= 2'h0;
    end else if (bvalid_o && bready_i) begin
      bvalid_o <= 1'b0;
      busy_q <= 1'b0;
      bid_o <= ~bid_o;
      bresp_o <= ~bresp_o;
    end
  end
endmodule

/* tb_acs_bridge.sv */
// Self-checking bench for the stash request bridge
`timescale 1ns/100ps
module tb_acs_bridge;
  import acs_pkg::*;
  logic clk_i, rst_i, s_awvalid_i, s_awready_o, s_awlock_i, s_awstashniden_i, s_awstashlpiden_i;
  logic s_bvalid_o, s_bready_i, m_awvalid_o, m_awready_i, m_awlock_o, m_awstashniden_o;
  logic m_awstashlpiden_o, m_bvalid_i, m_bready_o, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
  logic [3:0] s_awid_i, s_bid_o, m_awid_o, m_bid_i, s_awsnoop_i, m_awsnoop_o, s_awcache_i, m_awcache_o, wb_sel_i;
  logic [31:0] s_awaddr_i, m_awaddr_o, wb_dat_i, wb_dat_o, q, d_adr;
  logic [7:0] s_awlen_i, m_awlen_o, wb_adr_i;
  logic [2:0] s_awsize_i, m_awsize_o;
  logic [1:0] s_awburst_i, m_awburst_o, s_awdomain_i, m_awdomain_o, s_awbar_i, m_awbar_o, s_bresp_o, m_bresp_i;
  logic [10:0] s_awstashnid_i, m_awstashnid_o, d_nid;
  logic [4:0] s_awstashlpid_i, m_awstashlpid_o, d_lpid;
  logic [3:0] d_snp;
  logic [1:0] d_en;
  logic [21:0] d_ctl;
  int fail_count, n_compared, dn_n = 0;
  acs_bridge u_acs_bridge (.*);
  acs_sub_model u_acs_sub_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .awvalid_i(m_awvalid_o),
    .awready_o(m_awready_i), .awid_i(m_awid_o), .bvalid_o(m_bvalid_i), .bready_i(m_bready_o),
    .bid_o(m_bid_i), .bresp_o(m_bresp_i));

  // Capture what goes downstream at each accepted address
  always @(posedge clk_i) begin
    if (m_awvalid_o && m_awready_i) begin
      {d_snp, d_nid, d_lpid, d_adr} <= {m_awsnoop_o, m_awstashnid_o, m_awstashlpid_o, m_awaddr_o};
      d_en <= {m_awstashniden_o, m_awstashlpiden_o};
      d_ctl <= {m_awlen_o, m_awsize_o, m_awburst_o, m_awdomain_o, m_awcache_o, m_awlock_o, m_awbar_o};
      dn_n <= dn_n + 1;
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tmo();
    fail_count++;
    $display("[FAIL] %0t handshake timeout", $time);
    test_done();
  endtask

  // Classic cycle: ack and read data are taken at the same rising edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 50) tmo();
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  // Identifiers are zero whenever their enable is low
  task automatic aw(input logic [3:0] op, input logic [3:0] id, input logic [10:0] nid, input logic [1:0] en);
    int i;
    @(posedge clk_i);
    {s_awvalid_i, s_awsnoop_i, s_awid_i, s_awstashniden_i, s_awstashlpiden_i} <= {1'b1, op, id, en};
    {s_awstashnid_i, s_awstashlpid_i} <= {en[1] ? nid : 11'h0, en[0] ? nid[4:0] : 5'h0};
    s_awaddr_i <= 32'(nid) << 6;
    s_awdomain_i <= 2'h1 + id[0];
    s_awsize_i <= (op == SN_PTL_STASH) ? 3'h3 : 3'h6;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (s_awready_o === 1'b1) break;
    end
    if (i == 50) tmo();
    s_awvalid_i <= 1'b0;
  endtask

  task automatic bget(input logic [3:0] id);
    int i;
    s_bready_i <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (s_bvalid_o === 1'b1) break;
    end
    if (i == 50) tmo();
    chk(s_bid_o, id);
    chk(s_bresp_o, RESP_OKAY);
    s_bready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q[CTRL_FWD_BIT], CTRL_FWD_RST);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
  endtask

  // Write stashes reissued as unique and full-line unique writes, partial one's targets checked stripped
  task automatic t_conv();
    int n = dn_n;
    aw(SN_PTL_STASH, 4'h2, 11'h5A5, 2'b11);
    bget(4'h2);
    chk(d_snp, SN_UNIQUE);
    chk({d_nid, d_lpid, d_en}, 18'h0);
    chk(d_adr, 32'h0001_6940);
    slow <= 1'b1;
    aw(SN_FULL_STASH, 4'hB, 11'h7FF, 2'b10);
    bget(4'hB);
    slow <= 1'b0;
    chk(d_snp, SN_LINE_UNIQUE);
    chk(d_ctl, {8'h00, 3'h6, 2'h1, 2'h2, 4'h2, 1'b0, 2'h0});
    aw(SN_UNIQUE, 4'h1, 11'h000, 2'b00);
    bget(4'h1);
    chk({d_snp, d_en}, {SN_UNIQUE, 2'b00});
    chk(dn_n, n + 3);
  endtask

  // Stash-once pair on one ID, answered locally in order, nothing forwarded
  task automatic t_once();
    int n = dn_n;
    aw(SN_ONCE_SHARED, 4'h5, 11'h011, 2'b01);
    aw(SN_ONCE_UNIQUE, 4'h5, 11'h000, 2'b00);
    bget(4'h5);
    bget(4'h5);
    chk(dn_n, n);
    wb(1'b0, REG_CONV_CNT, 32'h0);
    chk(q, 32'h2);
    wb(1'b0, REG_ONCE_CNT, 32'h0);
    chk(q, 32'h2);
  endtask

  // Stash-capable downstream: requests pass unchanged with targets
  task automatic t_fwd();
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h1);
    aw(SN_PTL_STASH, 4'h3, 11'h2C3, 2'b11);
    bget(4'h3);
    chk({d_snp, d_nid, d_lpid, d_en}, {SN_PTL_STASH, 11'h2C3, 5'h03, 2'b11});
    aw(SN_ONCE_UNIQUE, 4'h9, 11'h000, 2'b00);
    bget(4'h9);
    chk({d_snp, d_en}, {SN_ONCE_UNIQUE, 2'b00});
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h0);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    {s_awvalid_i, s_awid_i, s_awaddr_i, s_awsnoop_i, s_awdomain_i, s_awstashnid_i} = '0;
    {s_awstashniden_i, s_awstashlpid_i, s_awstashlpiden_i, s_bready_i, slow} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, fail_count, n_compared} = '0;
    {s_awlen_i, s_awburst_i, s_awsize_i, wb_sel_i} = {8'h0, 2'h1, 3'h6, 4'hF};
    {s_awcache_i, s_awlock_i, s_awbar_i} = {4'h2, 1'b0, 2'h0};
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_conv();
    t_once();
    t_fwd();
    test_done();
  end
endmodule
